// ==== common/sdcd_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sdcd_if;
    import sdcd_pkg::*;
    logic clk_en;
    logic select_n;
    logic row_n;
    logic col_n;
    logic wr_n;
    logic [GRP_W-1:0] group_select;
    logic [ADDR_W-1:0] addr;
    modport ctrl (output clk_en, select_n, row_n, col_n, wr_n, group_select, addr);
    modport dev (input clk_en, select_n, row_n, col_n, wr_n, group_select, addr);
endinterface
`default_nettype wire

// ==== common/sdcd_pkg.sv ====
package sdcd_pkg;
    localparam int ADDR_W = 14;
    localparam int GRP_W = 3;
    localparam int NUM_GROUPS = 4;
    localparam int AUTO_CLOSE_POS = 10;
    localparam int COL_W = 10;
    localparam int NUM_MODE_REGS = 4;
    // command codes reported by the decoder
    typedef enum logic [3:0] {
        SDCD_CMD_NONE = 4'h0,
        SDCD_CMD_MODE_LOAD = 4'h1,
        SDCD_CMD_REFRESH = 4'h2,
        SDCD_CMD_SREF_ENTER = 4'h3,
        SDCD_CMD_SREF_EXIT = 4'h4,
        SDCD_CMD_PRE_ONE = 4'h5,
        SDCD_CMD_PRE_ALL = 4'h6,
        SDCD_CMD_ACTIVATE = 4'h7,
        SDCD_CMD_WRITE = 4'h8,
        SDCD_CMD_WRITE_AC = 4'h9,
        SDCD_CMD_READ = 4'hA,
        SDCD_CMD_READ_AC = 4'hB,
        SDCD_CMD_NOP = 4'hC,
        SDCD_CMD_DESELECT = 4'hD,
        SDCD_CMD_PD_ENTER = 4'hE,
        SDCD_CMD_PD_EXIT = 4'hF
    } sdcd_cmd_t;
    // device power states, one-hot
    typedef enum logic [2:0] {
        SDCD_PW_ACTIVE = 3'h1,
        SDCD_PW_DOWN = 3'h2,
        SDCD_PW_SREF = 3'h4
    } sdcd_pwr_t;
    // strobe pattern {select_n, row_n, col_n, wr_n}
    localparam logic [3:0] PAT_MODE = 4'h0;
    localparam logic [3:0] PAT_REFRESH = 4'h1;
    localparam logic [3:0] PAT_PRECHARGE = 4'h2;
    localparam logic [3:0] PAT_ACTIVATE = 4'h3;
    localparam logic [3:0] PAT_WRITE = 4'h4;
    localparam logic [3:0] PAT_READ = 4'h5;
    localparam logic [3:0] PAT_NOP = 4'h7;
    localparam int BURST_LEN = 4;
    localparam int BURST_CNT_W = 3;
endpackage

// ==== design/sdcd_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdcd_ctrl
    import sdcd_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire sdcd_cmd_t req_cmd_i,
    input wire logic [GRP_W-1:0] req_group_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    output logic req_ready_o,
    sdcd_if.ctrl bus
);
    ////////////////////////////////////////////////////////////////////
    logic cke_reg, cke_next;
    logic [3:0] pat_reg, pat_next;
    logic [GRP_W-1:0] grp_reg, grp_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;

    assign req_ready_o = 1'b1;

    // translate request to pins, one command per cycle
    always_comb begin
        cke_next = cke_reg;
        pat_next = PAT_NOP;
        grp_next = '0;
        addr_next = '0;
        if (req_valid_i) begin
            grp_next = req_group_i;
            addr_next = req_addr_i;
            case (req_cmd_i)
                SDCD_CMD_MODE_LOAD: pat_next = PAT_MODE;
                SDCD_CMD_REFRESH: pat_next = PAT_REFRESH;
                SDCD_CMD_SREF_ENTER: begin
                    pat_next = PAT_REFRESH;
                    cke_next = 1'b0;
                end
                SDCD_CMD_SREF_EXIT, SDCD_CMD_PD_EXIT: cke_next = 1'b1;
                SDCD_CMD_PD_ENTER: cke_next = 1'b0;
                SDCD_CMD_PRE_ONE: begin
                    pat_next = PAT_PRECHARGE;
                    addr_next[AUTO_CLOSE_POS] = 1'b0;
                end
                SDCD_CMD_PRE_ALL: begin
                    pat_next = PAT_PRECHARGE;
                    addr_next[AUTO_CLOSE_POS] = 1'b1;
                end
                SDCD_CMD_ACTIVATE: pat_next = PAT_ACTIVATE;
                SDCD_CMD_WRITE, SDCD_CMD_WRITE_AC: begin
                    pat_next = PAT_WRITE;
                    addr_next[AUTO_CLOSE_POS] = (req_cmd_i == SDCD_CMD_WRITE_AC);
                end
                SDCD_CMD_READ, SDCD_CMD_READ_AC: begin
                    pat_next = PAT_READ;
                    addr_next[AUTO_CLOSE_POS] = (req_cmd_i == SDCD_CMD_READ_AC);
                end
                SDCD_CMD_DESELECT: pat_next = 4'h8;
                default: pat_next = PAT_NOP;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cke_reg <= 1'b1;
            pat_reg <= PAT_NOP;
            grp_reg <= '0;
            addr_reg <= '0;
        end else begin
            cke_reg <= cke_next;
            pat_reg <= pat_next;
            grp_reg <= grp_next;
            addr_reg <= addr_next;
        end
    end

    // registered pins, sampled by the device at the next edge
    assign bus.clk_en = cke_reg;
    assign bus.select_n = pat_reg[3];
    assign bus.row_n = pat_reg[2];
    assign bus.col_n = pat_reg[1];
    assign bus.wr_n = pat_reg[0];
    assign bus.group_select = grp_reg;
    assign bus.addr = addr_reg;
endmodule
`default_nettype wire

// ==== design/sdcd_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - commands decoded from strobes and clock enable
// - all strobes low loads a mode register
// - group select picks the mode register
// - refresh pattern with enable falling enters self refresh
// - enable rising with idle pattern leaves self refresh
// - self refresh exit is only seen on clock_i edges, through the synchronisers
// - precharge closes one bank or all
// - activate opens row in chosen bank
// - write starts burst at column
// - write with auto close closes bank after burst
// - read starts burst at column
// - read with auto close closes bank after burst
// - nop and deselect start nothing
// - enable falling with idle pattern enters power-down
// - enable rising with idle pattern leaves power-down
module sdcd_dev
    import sdcd_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    sdcd_if.dev bus,
    output sdcd_cmd_t cmd_o,
    output logic cmd_valid_o,
    output logic illegal_o,
    output logic [NUM_GROUPS-1:0] bank_open_o,
    output logic [NUM_GROUPS-1:0] burst_busy_o,
    output logic refresh_o,
    output logic [2:0] pwr_state_o,
    output logic [ADDR_W-1:0] mode_reg_o [NUM_MODE_REGS],
    output logic [ADDR_W-1:0] open_row_o [NUM_GROUPS],
    output logic [COL_W-1:0] column_o
);
    ////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [3+GRP_W+ADDR_W+1:0] s1_reg, s2_reg;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s1_reg <= {1'b1, PAT_NOP, GRP_W'(0), ADDR_W'(0)};
            s2_reg <= {1'b1, PAT_NOP, GRP_W'(0), ADDR_W'(0)};
        end else begin
            s1_reg <= {bus.clk_en, bus.select_n, bus.row_n, bus.col_n, bus.wr_n,
                bus.group_select, bus.addr};
            s2_reg <= s1_reg;
        end
    end
    logic cke_cur;
    logic [3:0] pat;
    logic [GRP_W-1:0] grp;
    logic [ADDR_W-1:0] adr;
    assign {cke_cur, pat, grp, adr} = s2_reg;
    logic [1:0] bank;
    assign bank = grp[1:0];
    logic ac;
    assign ac = adr[AUTO_CLOSE_POS];

    ////////////////////////////////////////////////////////////////////
    // decode
    logic cke_prev_reg;
    sdcd_pwr_t pwr_reg, pwr_next;
    sdcd_cmd_t cmd;
    logic bad;
    logic idle_pat;
    always_comb begin
        cmd = SDCD_CMD_NONE;
        bad = 1'b0;
        idle_pat = pat[3] || (pat == PAT_NOP);
        case ({cke_prev_reg, cke_cur})
            2'b11: begin
                if (pat[3]) cmd = SDCD_CMD_DESELECT;
                else begin
                    case (pat)
                        PAT_MODE: cmd = SDCD_CMD_MODE_LOAD;
                        PAT_REFRESH: cmd = SDCD_CMD_REFRESH;
                        PAT_PRECHARGE: cmd = ac ? SDCD_CMD_PRE_ALL : SDCD_CMD_PRE_ONE;
                        PAT_ACTIVATE: cmd = SDCD_CMD_ACTIVATE;
                        PAT_WRITE: cmd = ac ? SDCD_CMD_WRITE_AC : SDCD_CMD_WRITE;
                        PAT_READ: cmd = ac ? SDCD_CMD_READ_AC : SDCD_CMD_READ;
                        PAT_NOP: cmd = SDCD_CMD_NOP;
                        default: bad = 1'b1;
                    endcase
                end
            end
            2'b10: begin
                if (pat == PAT_REFRESH) cmd = SDCD_CMD_SREF_ENTER;
                else if (idle_pat) cmd = SDCD_CMD_PD_ENTER;
                else bad = 1'b1;
            end
            2'b01: begin
                if (idle_pat) begin
                    cmd = (pwr_reg == SDCD_PW_SREF) ? SDCD_CMD_SREF_EXIT
                        : SDCD_CMD_PD_EXIT;
                end else bad = 1'b1;
            end
            default: cmd = SDCD_CMD_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // power state and banks
    logic [NUM_GROUPS-1:0] open_reg, open_next, ac_reg, ac_next;
    logic [BURST_CNT_W-1:0] cnt_reg [NUM_GROUPS];
    logic [BURST_CNT_W-1:0] cnt_next [NUM_GROUPS];
    logic [ADDR_W-1:0] mr_reg [NUM_MODE_REGS];
    logic [ADDR_W-1:0] mr_next [NUM_MODE_REGS];
    logic [ADDR_W-1:0] row_reg [NUM_GROUPS];
    logic [ADDR_W-1:0] row_next [NUM_GROUPS];
    logic [COL_W-1:0] col_reg, col_next;
    always_comb begin
        pwr_next = pwr_reg;
        open_next = open_reg;
        ac_next = ac_reg;
        cnt_next = cnt_reg;
        mr_next = mr_reg;
        row_next = row_reg;
        col_next = col_reg;
        for (int i = 0; i < NUM_GROUPS; i++) begin
            if (cnt_reg[i] != '0) begin
                cnt_next[i] = cnt_reg[i] - 1'b1;
                if (cnt_reg[i] == BURST_CNT_W'(1) && ac_reg[i]) begin
                    open_next[i] = 1'b0;
                    ac_next[i] = 1'b0;
                end
            end
        end
        case (cmd)
            SDCD_CMD_MODE_LOAD: mr_next[bank] = adr;
            SDCD_CMD_SREF_ENTER: pwr_next = SDCD_PW_SREF;
            SDCD_CMD_PD_ENTER: pwr_next = SDCD_PW_DOWN;
            SDCD_CMD_SREF_EXIT, SDCD_CMD_PD_EXIT: pwr_next = SDCD_PW_ACTIVE;
            SDCD_CMD_PRE_ONE: open_next[bank] = 1'b0;
            SDCD_CMD_PRE_ALL: open_next = '0;
            SDCD_CMD_ACTIVATE: begin
                open_next[bank] = 1'b1;
                row_next[bank] = adr;
            end
            SDCD_CMD_WRITE, SDCD_CMD_WRITE_AC, SDCD_CMD_READ, SDCD_CMD_READ_AC: begin
                col_next = adr[COL_W-1:0];
                cnt_next[bank] = BURST_CNT_W'(BURST_LEN);
                ac_next[bank] = ac;
            end
            default: pwr_next = pwr_reg;
        endcase
    end

    // self refresh is left on the synchronised enable, which needs clock_i running to be seen
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cke_prev_reg <= 1'b1;
            pwr_reg <= SDCD_PW_ACTIVE;
            open_reg <= '0;
            ac_reg <= '0;
            col_reg <= '0;
            for (int i = 0; i < NUM_GROUPS; i++) begin
                cnt_reg[i] <= '0;
                row_reg[i] <= '0;
            end
            for (int i = 0; i < NUM_MODE_REGS; i++) mr_reg[i] <= '0;
        end else begin
            cke_prev_reg <= cke_cur;
            pwr_reg <= pwr_next;
            open_reg <= open_next;
            ac_reg <= ac_next;
            cnt_reg <= cnt_next;
            mr_reg <= mr_next;
            row_reg <= row_next;
            col_reg <= col_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    sdcd_cmd_t cmd_reg;
    logic bad_reg;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_reg <= SDCD_CMD_NONE;
            bad_reg <= 1'b0;
        end else begin
            cmd_reg <= cmd;
            bad_reg <= bad;
        end
    end
    assign cmd_o = cmd_reg;
    assign cmd_valid_o = (cmd_reg != SDCD_CMD_NONE);
    assign illegal_o = bad_reg;
    assign bank_open_o = open_reg;
    always_comb begin
        for (int i = 0; i < NUM_GROUPS; i++) burst_busy_o[i] = (cnt_reg[i] != '0);
    end
    assign refresh_o = (cmd_reg == SDCD_CMD_REFRESH);
    assign pwr_state_o = pwr_reg;
    assign mode_reg_o = mr_reg;
    assign open_row_o = row_reg;
    assign column_o = col_reg;
endmodule
`default_nettype wire

// ==== verification/sdcd_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdcd_assertions
    import sdcd_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic clk_en,
    input wire logic select_n,
    input wire logic row_n,
    input wire logic col_n,
    input wire logic wr_n
);
    logic [3:0] pat;
    assign pat = {select_n, row_n, col_n, wr_n};
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    sequence s_held;
        $past(clk_en) && clk_en;
    endsequence
    sequence s_fall;
        $past(clk_en) && !clk_en;
    endsequence
    sequence s_rise;
        !$past(clk_en) && clk_en;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_mode_enabled: assert property (pat == PAT_MODE |-> s_held)
        else $error("mode load without enable held");
    a_refresh_prev_enabled: assert property (pat == PAT_REFRESH |-> $past(clk_en))
        else $error("refresh pattern after enable low");
    a_precharge_enabled: assert property (pat == PAT_PRECHARGE |-> s_held)
        else $error("precharge without enable held");
    a_activate_enabled: assert property (pat == PAT_ACTIVATE |-> s_held)
        else $error("activate without enable held");
    a_write_enabled: assert property (pat == PAT_WRITE |-> s_held)
        else $error("write without enable held");
    a_read_enabled: assert property (pat == PAT_READ |-> s_held)
        else $error("read without enable held");
    a_fall_pattern_ok: assert property (s_fall |-> select_n || pat == PAT_NOP || pat == PAT_REFRESH)
        else $error("enable fell with wrong pattern");
    a_rise_idle_pattern: assert property (s_rise |-> select_n || pat == PAT_NOP)
        else $error("enable rose with wrong pattern");
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sdcd_pkg::*;
;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid;
    sdcd_cmd_t req_cmd;
    logic [GRP_W-1:0] req_group;
    logic [ADDR_W-1:0] req_addr;
    sdcd_cmd_t cmd;
    logic cmd_valid, illegal, illegal_2, refresh;
    logic req_ready;
    logic [NUM_GROUPS-1:0] bank_open, burst_busy, bank_open_2;
    logic [2:0] pwr_state;
    logic [ADDR_W-1:0] mode_reg [NUM_MODE_REGS];
    logic [ADDR_W-1:0] open_row [NUM_GROUPS];
    logic [COL_W-1:0] column;
    int failures = 0;
    int compares = 0;
    sdcd_if bus();
    sdcd_if bus2();
    ////////////////////////////////////////////////////////////////////////////////
    sdcd_ctrl u_sdcd_ctrl(.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid),
        .req_cmd_i(req_cmd), .req_group_i(req_group), .req_addr_i(req_addr),
        .req_ready_o(req_ready), .bus(bus));
    sdcd_dev u_sdcd_dev(.clock_i(clock_i), .rst_i(rst_i), .bus(bus), .cmd_o(cmd),
        .cmd_valid_o(cmd_valid), .illegal_o(illegal), .bank_open_o(bank_open),
        .burst_busy_o(burst_busy), .refresh_o(refresh), .pwr_state_o(pwr_state),
        .mode_reg_o(mode_reg), .open_row_o(open_row), .column_o(column));
    sdcd_dev u_sdcd_dev_2(.clock_i(clock_i), .rst_i(rst_i), .bus(bus2), .cmd_o(),
        .cmd_valid_o(), .illegal_o(illegal_2), .bank_open_o(bank_open_2), .burst_busy_o(),
        .refresh_o(), .pwr_state_o(), .mode_reg_o(), .open_row_o(), .column_o());
    sdcd_assertions u_sdcd_assertions(.clock_i(clock_i), .rst_i(rst_i), .clk_en(bus.clk_en),
        .select_n(bus.select_n), .row_n(bus.row_n), .col_n(bus.col_n), .wr_n(bus.wr_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic send(input sdcd_cmd_t c, input logic [GRP_W-1:0] g, input logic [ADDR_W-1:0] a);
        req_valid = 1'b1;
        req_cmd = c;
        req_group = g;
        req_addr = a;
        @(posedge clock_i);
        #1;
    endtask
    task automatic run(input sdcd_cmd_t c, input logic [GRP_W-1:0] g, input logic [ADDR_W-1:0] a);
        send(c, g, a);
        req_valid = 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
        chk(cmd === c && cmd_valid === 1'b1, "decoded command");
        chk(illegal === 1'b0 && req_ready === 1'b1, "stray illegal");
    endtask
    task automatic t_reset;
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            #1;
            seen = seen | (cmd === SDCD_CMD_PD_EXIT);
        end
        chk(!seen && cmd === SDCD_CMD_NOP && pwr_state === SDCD_PW_ACTIVE, "reset state");
        chk(bank_open === 4'h0 && illegal === 1'b0, "reset banks");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_mode;
        for (int g = 0; g < NUM_MODE_REGS; g++) begin
            run(SDCD_CMD_MODE_LOAD, GRP_W'(g), ADDR_W'(14'h0230 + g));
            chk(mode_reg[g] === ADDR_W'(14'h0230 + g), "mode register");
        end
        run(SDCD_CMD_REFRESH, 3'h1, 14'h3FFF);
        chk(refresh === 1'b1, "refresh pulse");
        chk(bank_open === 4'h0, "refresh opened bank");
    endtask
    task automatic t_precharge;
        send(SDCD_CMD_ACTIVATE, 3'h0, 14'h0011);
        run(SDCD_CMD_ACTIVATE, 3'h1, 14'h0022);
        run(SDCD_CMD_NOP, 3'h0, 14'h3FFF);
        run(SDCD_CMD_DESELECT, 3'h1, 14'h3FFF);
        chk(bank_open === 4'h3 && open_row[1] === 14'h0022, "idle changed bank");
        run(SDCD_CMD_READ, 3'h1, 14'h0345);
        chk(column === 10'h345 && burst_busy[1] === 1'b1, "read start");
        run(SDCD_CMD_WRITE, 3'h1, 14'h02AB);
        chk(column === 10'h2AB && bank_open === 4'h3, "write start");
        run(SDCD_CMD_PRE_ONE, 3'h0, 14'h0000);
        chk(bank_open === 4'h2, "single close");
        run(SDCD_CMD_PRE_ALL, 3'h0, 14'h0000);
        chk(bank_open === 4'h0, "all close");
    endtask
    task automatic t_burst(input sdcd_cmd_t c);
        run(SDCD_CMD_ACTIVATE, 3'h2, 14'h1ABC);
        chk(bank_open[2] === 1'b1 && open_row[2] === 14'h1ABC, "row open");
        run(c, 3'h2, 14'h0123);
        chk(column === 10'h123 && burst_busy[2] === 1'b1 && bank_open[2] === 1'b1, "burst");
        repeat (BURST_LEN) @(posedge clock_i);
        #1;
        chk(bank_open[2] === 1'b0 && burst_busy[2] === 1'b0, "auto close");
    endtask
    task automatic t_power;
        run(SDCD_CMD_PD_ENTER, 3'h0, 14'h0000);
        chk(pwr_state === SDCD_PW_DOWN, "power-down entry");
        run(SDCD_CMD_PD_EXIT, 3'h0, 14'h0000);
        chk(pwr_state === SDCD_PW_ACTIVE, "power-down exit");
        run(SDCD_CMD_SREF_ENTER, 3'h0, 14'h0000);
        chk(pwr_state === SDCD_PW_SREF, "self refresh entry");
        run(SDCD_CMD_SREF_EXIT, 3'h0, 14'h0000);
        chk(pwr_state === SDCD_PW_ACTIVE, "self refresh exit");
    endtask
    task automatic t_illegal;
        logic seen;
        seen = 1'b0;
        bus2.clk_en = 1'b0;
        {bus2.select_n, bus2.row_n, bus2.col_n, bus2.wr_n} = PAT_ACTIVATE;
        @(posedge clock_i);
        #1;
        bus2.clk_en = 1'b1;
        {bus2.select_n, bus2.row_n, bus2.col_n, bus2.wr_n} = PAT_NOP;
        for (int i = 0; i < 6; i++) begin
            @(posedge clock_i);
            #1;
            seen = seen | illegal_2;
        end
        chk(seen === 1'b1 && bank_open_2 === 4'h0, "illegal pattern");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #50 clock_i = ~clock_i;
    end
    initial begin
        repeat (3000) @(posedge clock_i);
        failures++;
        tally_and_finish();
    end
    initial begin
        req_valid = 1'b0;
        req_cmd = SDCD_CMD_NONE;
        req_group = 3'h0;
        req_addr = 14'h0000;
        bus2.clk_en = 1'b1;
        {bus2.select_n, bus2.row_n, bus2.col_n, bus2.wr_n} = PAT_NOP;
        bus2.group_select = 3'h0;
        bus2.addr = 14'h0000;
        repeat (10) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        t_reset();
        t_mode();
        t_precharge();
        t_burst(SDCD_CMD_WRITE_AC);
        t_burst(SDCD_CMD_READ_AC);
        t_power();
        t_illegal();
        tally_and_finish();
    end
endmodule
`default_nettype wire
